// File: core/spirp_port.sv
// Purpose: serial target port giving a host byte access to a register map
// Assumes: sck, cs_n, mosi, shutdown_n asynchronous to clk; sck well below clk/3
// Notes: register storage lives outside; rd_data must follow rd_addr within one clk
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: a falling chip select starts a new command frame.
// RULE2: the data input is sampled on each rising serial clock edge while chip select is low.
// RULE3: all words are eight bits, counted by a three-bit bit counter.
// RULE4: the host sends command byte, then address byte, then data bytes.
// RULE5: a command with a zero read bit makes every data byte a register write.
// RULE6: the host keeps the serial clock at or below 12 MHz.
// RULE7: on the eighth rising edge of each written byte the address pointer steps by one.
// RULE8: the step repeats for every further written byte in the frame.
// RULE9: a command with bit 7 set makes the frame a read.
// RULE10: after command and address, the addressed register is shifted out on the data output.
// RULE11: on the eighth rising edge of each read byte the address pointer steps by one.
// RULE12: any address may be read, its value coming from the register map.
// RULE13: a rising edge on the shutdown pin returns the port to idle.
// RULE14: the data output changes only after a falling serial clock edge.
// RULE15: chip select going high ends the frame, clears the count and releases the output.
module spirp_port (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    input  wire logic              shutdown_n_pin,
    input  wire logic [7:0]        rd_data,
    output logic                   miso_o,
    output logic                   miso_oe,
    output logic [7:0]             rd_addr,
    output spirp_pkg::spirp_wr_t   wr
);
    spirp_pkg::spirp_state_t r;
    spirp_pkg::spirp_state_t r_nxt;

    logic sck_rise;
    logic sck_fall;
    logic cs_fell;
    logic cs_high;
    logic sd_rise;

    assign sck_rise = r.sck_s2 & ~r.sck_d;
    assign sck_fall = ~r.sck_s2 & r.sck_d;
    assign cs_fell  = ~r.cs_s2 & r.cs_d;
    assign cs_high  = r.cs_s2;
    assign sd_rise  = r.sd_s2 & ~r.sd_d;

    always_comb
    begin
        r_nxt         = r;
        r_nxt.sck_s1  = sck;
        r_nxt.sck_s2  = r.sck_s1;
        r_nxt.sck_d   = r.sck_s2;
        r_nxt.cs_s1   = cs_n;
        r_nxt.cs_s2   = r.cs_s1;
        r_nxt.cs_d    = r.cs_s2;
        r_nxt.mosi_s1 = mosi;
        r_nxt.mosi_s2 = r.mosi_s1;
        r_nxt.sd_s1   = shutdown_n_pin;
        r_nxt.sd_s2   = r.sd_s1;
        r_nxt.sd_d    = r.sd_s2;
        r_nxt.wr.en   = 1'b0;
        if (sd_rise || cs_high)
        begin
            // frame over or port reset
            r_nxt.phase   = spirp_pkg::SPIRP_IDLE;                     // RULE13
            r_nxt.bit_cnt = spirp_pkg::CNT_RST;                        // RULE15
            r_nxt.is_read = 1'b0;
            r_nxt.miso    = 1'b0;
            r_nxt.miso_oe = 1'b0;                                      // RULE15
        end
        else if (cs_fell)
        begin
            r_nxt.phase   = spirp_pkg::SPIRP_CMD;                      // RULE1
            r_nxt.bit_cnt = spirp_pkg::CNT_RST;
            r_nxt.is_read = 1'b0;
            r_nxt.miso_oe = 1'b1;
        end
        else if (r.phase != spirp_pkg::SPIRP_IDLE)
        begin
            if (sck_rise)
            begin
                r_nxt.shreg   = {r.shreg[6:0], r.mosi_s2};             // RULE2
                r_nxt.bit_cnt = r.bit_cnt + 3'h1;                      // RULE3
                if (r.bit_cnt == spirp_pkg::CNT_LAST)
                begin
                    case (r.phase)
                        spirp_pkg::SPIRP_CMD:
                        begin
                            r_nxt.is_read = r.shreg[spirp_pkg::RW_BIT - 1]; // RULE9
                            r_nxt.phase   = spirp_pkg::SPIRP_ADDR;     // RULE4
                        end
                        spirp_pkg::SPIRP_ADDR:
                        begin
                            r_nxt.addr  = {r.shreg[6:0], r.mosi_s2};
                            r_nxt.phase = spirp_pkg::SPIRP_DATA;
                        end
                        spirp_pkg::SPIRP_DATA:
                        begin
                            if (!r.is_read)
                            begin
                                r_nxt.wr.en   = 1'b1;                  // RULE5
                                r_nxt.wr.addr = r.addr;
                                r_nxt.wr.data = {r.shreg[6:0], r.mosi_s2};
                            end
                            r_nxt.addr = r.addr + spirp_pkg::ADDR_STEP; // RULE7 RULE8 RULE11
                        end
                        default:
                        begin
                            r_nxt.phase   = spirp_pkg::SPIRP_IDLE;
                            r_nxt.miso    = 1'b0;
                            r_nxt.miso_oe = 1'b0;
                        end
                    endcase
                end
            end
            else if (sck_fall && r.phase == spirp_pkg::SPIRP_DATA && r.is_read)
            begin
                if (r.bit_cnt == spirp_pkg::CNT_RST)
                begin
                    r_nxt.miso = rd_data[7];                           // RULE10 RULE12 RULE14
                    r_nxt.tx   = {rd_data[6:0], 1'b0};
                end
                else
                begin
                    r_nxt.miso = r.tx[7];                              // RULE14
                    r_nxt.tx   = {r.tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r         <= '0;
            r.cs_s1   <= 1'b1;
            r.cs_s2   <= 1'b1;
            r.cs_d    <= 1'b1;
            r.sd_s1   <= 1'b1;
            r.sd_s2   <= 1'b1;
            r.sd_d    <= 1'b1;
            r.phase   <= spirp_pkg::SPIRP_IDLE;
            r.addr    <= spirp_pkg::BYTE_RST;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign miso_o  = r.miso;
    assign miso_oe = r.miso_oe;
    assign rd_addr = r.addr;                                           // RULE12
    assign wr      = r.wr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    frame_start_a: assert property (cs_fell && !sd_rise && !cs_high |=> // RULE1
        r.phase == spirp_pkg::SPIRP_CMD && r.bit_cnt == spirp_pkg::CNT_RST)
        else $error("frame did not start on chip select fall");

    mosi_sample_a: assert property (sck_rise && r.phase != spirp_pkg::SPIRP_IDLE // RULE2
        && !cs_high && !sd_rise |=> r.shreg[0] == $past(r.mosi_s2))
        else $error("input bit not sampled on rising edge");

    bit_count_a: assert property (sck_rise && r.phase != spirp_pkg::SPIRP_IDLE // RULE3
        && !cs_high && !sd_rise |=> r.bit_cnt == 3'($past(r.bit_cnt) + 3'h1))
        else $error("bit counter did not step");

    write_store_a: assert property (sck_rise && r.phase == spirp_pkg::SPIRP_DATA // RULE5
        && !r.is_read && r.bit_cnt == spirp_pkg::CNT_LAST && !cs_high && !sd_rise
        |=> wr.en && wr.data == r.shreg && wr.addr == $past(r.addr))
        else $error("write byte not stored");

    write_step_a: assert property (wr.en |-> r.addr == 8'(wr.addr + 8'h01)) // RULE7
        else $error("address did not step after write");

    read_quiet_a: assert property (r.is_read |-> !wr.en) // RULE9
        else $error("write issued during read frame");

    read_load_a: assert property (sck_fall && r.phase == spirp_pkg::SPIRP_DATA // RULE10
        && r.is_read && r.bit_cnt == spirp_pkg::CNT_RST && !cs_high && !sd_rise
        |=> miso_o == $past(rd_data[7]))
        else $error("read byte not presented");

    read_step_a: assert property (sck_rise && r.phase == spirp_pkg::SPIRP_DATA // RULE11
        && r.is_read && r.bit_cnt == spirp_pkg::CNT_LAST && !cs_high && !sd_rise
        |=> r.addr == 8'($past(r.addr) + 8'h01))
        else $error("address did not step after read byte");

    shut_idle_a: assert property (sd_rise |=> r.phase == spirp_pkg::SPIRP_IDLE // RULE13
        && !miso_oe)
        else $error("shutdown edge did not idle the port");

    miso_edge_a: assert property ($changed(miso_o) && !$past(cs_high) // RULE14
        && !$past(sd_rise) |-> $past(sck_fall))
        else $error("output changed away from falling edge");

    frame_end_a: assert property (cs_high |=> !miso_oe && !miso_o // RULE15
        && r.phase == spirp_pkg::SPIRP_IDLE && r.bit_cnt == spirp_pkg::CNT_RST)
        else $error("frame not ended on chip select high");

    cmd_decode_a: assert property (sck_rise && r.phase == spirp_pkg::SPIRP_CMD // RULE9
        && r.bit_cnt == spirp_pkg::CNT_LAST
        && !cs_high && !sd_rise
        |=> r.is_read == $past(r.shreg[6]) && r.phase == spirp_pkg::SPIRP_ADDR)
        else $error("read bit not taken from command");

    addr_load_a: assert property (sck_rise && r.phase == spirp_pkg::SPIRP_ADDR // RULE4
        && r.bit_cnt == spirp_pkg::CNT_LAST
        && !cs_high && !sd_rise
        |=> r.phase == spirp_pkg::SPIRP_DATA && r.addr == r.shreg)
        else $error("address byte not loaded");

    cmd_wait_a: assert property (r.phase == spirp_pkg::SPIRP_CMD && !cs_high // RULE4
        && !sd_rise
        && !(sck_rise && r.bit_cnt == spirp_pkg::CNT_LAST)
        |=> r.phase == spirp_pkg::SPIRP_CMD)
        else $error("command phase left early");

    data_hold_a: assert property (r.phase == spirp_pkg::SPIRP_DATA // RULE8
        && !cs_high
        && !sd_rise
        |=> r.phase == spirp_pkg::SPIRP_DATA)
        else $error("data phase left while selected");

    oe_start_a: assert property (cs_fell // RULE1
        && !sd_rise
        |=> miso_oe && !r.is_read)
        else $error("output not enabled at frame start");

    oe_active_a: assert property (r.phase != spirp_pkg::SPIRP_IDLE // RULE1
        |-> miso_oe)
        else $error("output disabled inside a frame");

    idle_quiet_a: assert property (r.phase == spirp_pkg::SPIRP_IDLE // RULE15
        |-> !miso_oe && !miso_o
        && r.bit_cnt == spirp_pkg::CNT_RST
        && !wr.en)
        else $error("idle port not quiet");

    wr_pulse_a: assert property (wr.en // RULE5
        |=> !wr.en)
        else $error("write strobe longer than one cycle");

    wr_shape_a: assert property (wr.en // RULE3
        |-> r.bit_cnt == spirp_pkg::CNT_RST
        && r.phase == spirp_pkg::SPIRP_DATA
        && !r.is_read)
        else $error("write outside a whole data byte");

    wr_keep_a: assert property ($changed(wr.data) || $changed(wr.addr) // RULE5
        |-> wr.en)
        else $error("write fields moved without a strobe");

    idle_ignore_a: assert property (sck_rise && r.phase == spirp_pkg::SPIRP_IDLE // RULE13
        |=> $stable(r.shreg)
        && $stable(r.bit_cnt))
        else $error("clock taken while port idle");

    shut_quiet_a: assert property (sd_rise // RULE13
        |=> !wr.en
        && r.bit_cnt == spirp_pkg::CNT_RST)
        else $error("shutdown edge left the port busy");

    read_shift_a: assert property (sck_fall && r.phase == spirp_pkg::SPIRP_DATA // RULE14
        && r.is_read && r.bit_cnt != spirp_pkg::CNT_RST
        && !cs_high && !sd_rise
        |=> miso_o == $past(r.tx[7]))
        else $error("read bit not shifted on falling edge");

    miso_hold_a: assert property (!sck_fall && !cs_high && !sd_rise // RULE14
        |=> $stable(miso_o))
        else $error("output moved without a falling edge");

    addr_move_a: assert property ($changed(r.addr) // RULE7
        |-> $past(sck_rise)
        && $past(r.bit_cnt) == spirp_pkg::CNT_LAST)
        else $error("address moved away from a byte end");

    cnt_hold_a: assert property (!sck_rise && !cs_high && !sd_rise && !cs_fell // RULE3
        |=> $stable(r.bit_cnt))
        else $error("bit counter moved without a clock edge");

    tx_load_a: assert property (sck_fall && r.phase == spirp_pkg::SPIRP_DATA // RULE10
        && r.is_read && r.bit_cnt == spirp_pkg::CNT_RST
        && !cs_high && !sd_rise
        |=> r.tx == {$past(rd_data[6:0]), 1'b0})
        else $error("read byte not loaded for shifting");

    oe_hold_a: assert property (!cs_high && !sd_rise && !cs_fell // RULE15
        |=> $stable(miso_oe))
        else $error("output enable moved inside a frame");

    addr_keep_a: assert property (cs_high // RULE15
        |=> $stable(r.addr))
        else $error("address lost at frame end");
endmodule : spirp_port
`default_nettype wire

// File: inc/spirp_pkg.sv
// Purpose: shared constants and types for the serial register port
// Assumes: byte-wide register map held outside the port
// Notes: no time counts are needed; the sck ceiling is kept for reference
package spirp_pkg;
    localparam int unsigned      WORD_BITS   = 8;
    localparam int unsigned      RW_BIT      = 7;
    localparam int unsigned      CLK_HZ      = 40_000_000;
    localparam int unsigned      SCK_MAX_HZ  = 12_000_000;
    localparam logic [2:0]       CNT_RST     = 3'h0;
    localparam logic [2:0]       CNT_LAST    = 3'h7;
    localparam logic [7:0]       BYTE_RST    = 8'h00;
    localparam logic [7:0]       ADDR_STEP   = 8'h01;

    typedef enum logic [1:0] {
        SPIRP_IDLE = 2'b00,
        SPIRP_CMD  = 2'b01,
        SPIRP_ADDR = 2'b10,
        SPIRP_DATA = 2'b11
    } spirp_phase_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } spirp_wr_t;

    typedef struct packed {
        logic         sck_s1;
        logic         sck_s2;
        logic         sck_d;
        logic         cs_s1;
        logic         cs_s2;
        logic         cs_d;
        logic         mosi_s1;
        logic         mosi_s2;
        logic         sd_s1;
        logic         sd_s2;
        logic         sd_d;
        spirp_phase_t phase;
        logic [2:0]   bit_cnt;
        logic [7:0]   shreg;
        logic         is_read;
        logic [7:0]   addr;
        logic [7:0]   tx;
        logic         miso;
        logic         miso_oe;
        spirp_wr_t    wr;
    } spirp_state_t;
endpackage : spirp_pkg

// File: verif/spirp_host.sv
// Purpose: host model driving the serial register port
// Assumes: mode 0, serial clock 200 ns, clk 25 ns
// Notes: mosi toggles while deselected
`timescale 1ns/10ps
`default_nettype none
module spirp_host (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sck,
    output logic      cs_n,
    output logic      mosi
);
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task sel(input logic on);
        @(posedge clk) cs_n <= ~on;
        repeat (8) @(posedge clk);
        if (!on)
            mosi <= ~mosi;
    endtask : sel
    // msb first, 4 clk per half period
    task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            @(posedge clk) mosi <= tx[i];
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            rx[i] = miso;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
    endtask : xfer
endmodule : spirp_host
`default_nettype wire

// File: verif/test_spirp_port.sv
// Purpose: self-checking bench for the serial register port
// Assumes: 40 MHz clk, 5 MHz serial clock from the host model
// Notes: register map and write model kept in the bench
`timescale 1ns/10ps
`default_nettype none
module test_spirp_port;
    logic                 clk;
    logic                 srst;
    logic                 sck;
    logic                 cs_n;
    logic                 mosi;
    logic                 shutdown_n_pin;
    logic                 miso_o;
    logic                 miso_oe;
    logic [7:0]           rd_addr;
    spirp_pkg::spirp_wr_t wr;
    logic [7:0]           ref_m [256];
    logic [15:0]          exp_q [$];
    int                   error_cnt = 0;
    int                   comparisons = 0;
    spirp_port i_spirp_port (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
        .shutdown_n_pin(shutdown_n_pin), .rd_data(ref_m[rd_addr]), .miso_o(miso_o),
        .miso_oe(miso_oe), .rd_addr(rd_addr), .wr(wr));
    spirp_host i_spirp_host (.clk(clk), .miso(miso_o), .sck(sck), .cs_n(cs_n), .mosi(mosi));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task final_report;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    always @(negedge clk)
        if (wr.en === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("wr_extra", 16'h0000, 16'h0001);
            else
                chk("wr", exp_q.pop_front(), {wr.addr, wr.data});
        end
    // cut below 0: whole frame; 0: shutdown pulse then a byte; else partial byte
    task frame(input logic [7:0] cmd, input logic [7:0] a0, input int n, input int cut);
        logic [7:0] rx;
        logic [7:0] d;
        logic [7:0] a;
        a = a0;
        i_spirp_host.sel(1'b1);
        i_spirp_host.xfer(cmd, 8, rx);
        i_spirp_host.xfer(a, 8, rx);
        for (int k = 0; k < n; k++)
        begin
            d = 8'($urandom);
            if (!cmd[7])
            begin
                exp_q.push_back({a, d});
                ref_m[a] = d;
            end
            i_spirp_host.xfer(d, 8, rx);
            if (cmd[7])
                chk("rd", 16'(ref_m[a]), 16'(rx));
            chk("oe", 16'h0001, 16'(miso_oe));
            a = a + 8'h01;
        end
        if (cut == 0)
        begin
            @(posedge clk) shutdown_n_pin <= 1'b0;
            repeat (8) @(posedge clk);
            shutdown_n_pin <= 1'b1;
            repeat (8) @(posedge clk);
            chk("oe_sd", 16'h0000, 16'(miso_oe));
        end
        if (cut >= 0)
            i_spirp_host.xfer(8'($urandom), (cut == 0) ? 8 : cut, rx);
        i_spirp_host.sel(1'b0);
        chk("ptr", 16'(a), 16'(rd_addr));
        chk("oe_off", 16'h0000, 16'(miso_oe));
        $display("test frame %h %h %0d done", cmd, a0, cut);
    endtask : frame
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #500us;
        error_cnt++;
        final_report();
    end
    initial
    begin
        srst = 1'b1;
        shutdown_n_pin = 1'b1;
        void'($urandom(32'h4aca_2d02));
        for (int i = 0; i < 256; i++)
            ref_m[i] = 8'($urandom);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        frame(8'h00, 8'hfe, 3, -1);
        frame(8'h55, 8'h10, 2, -1);
        frame(8'hff, 8'hfd, 4, -1);
        frame(8'h80, 8'h42, 1, -1);
        frame(8'h00, 8'h20, 0, 5);
        frame(8'h00, 8'h21, 0, 0);
        frame(8'h80, 8'h1f, 2, -1);
        chk("wr_left", 16'h0000, 16'(exp_q.size()));
        final_report();
    end
endmodule : test_spirp_port
`default_nettype wire
